// File: bench/acpm_checker.sv
// port assertions for the channel mode controller
// assumes one mclk domain; bound to every acpm_ctrl
module acpm_checker #(
    parameter int SETTLE = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear_n,
    input wire logic por_active,
    input wire acpm_pkg::acpm_mode_s mode,
    input wire logic [3:0] sample_stb,
    input wire logic [95:0] ch_data,
    input wire logic [15:0] modulator_output_register,
    input wire logic [3:0] ch_drdy,
    input wire logic [3:0] ch_active,
    input wire acpm_pkg::acpm_power_s power
);
    localparam int LO = SETTLE - 1;
    localparam int HI = SETTLE + 1;
    logic hard;
    logic full;
    logic [3:0] busy;
    assign hard = !clear_n || por_active;
    assign busy = mode.soft_hold | mode.shutdown;
    assign full = mode.shutdown == 4'hF && mode.ext_reference_select && mode.ext_clock_select;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_freed;
        !hard && $fell(busy[0]);
    endsequence
    a_parked_quiet: assert property (busy != 4'h0 |=> (ch_drdy & $past(busy)) == 4'h0)
        else $error("parked pulse");
    a_drdy_on_strobe: assert property (ch_drdy != 4'h0 |-> (ch_drdy & ~$past(sample_stb)) == 4'h0)
        else $error("pulse off strobe");
    for (genvar i = 0; i < 4; i++) begin : g_ch
        a_parked_zero: assert property (busy[i] |=> ch_data[24*i+:24] == 24'h0 &&
            modulator_output_register[4*i+:4] == 4'h3) else $error("parked output");
    end
    a_hard_clear: assert property (hard |=> ch_data == 96'h0 && ch_drdy == 4'h0 &&
        modulator_output_register == 16'h3333 && power.if_reset) else $error("hard reset");
    a_core_gate: assert property (!hard |=> power.core_clk_en == ($past(busy) != 4'hF))
        else $error("core clock");
    a_input_gate: assert property (!hard |=>
        power.input_clk_en == ($past(mode.shutdown) != 4'hF)) else $error("input clock");
    a_full_state: assert property (!hard |=> power.full_shutdown == $past(full) &&
        power.ref_en == !$past(full)) else $error("full shutdown");
    a_monitor_back: assert property ($fell(full) && !hard |=> power.supply_mon_en)
        else $error("monitors off");
    a_settle_time: assert property (s_freed |=> !ch_active[0] ##[LO:HI] ch_active[0])
        else $error("settle time");
endmodule
bind acpm_ctrl acpm_checker #(.SETTLE(SETTLE)) u_chk (.mclk, .rst_n, .clear_n, .por_active,
    .mode, .sample_stb, .ch_data, .modulator_output_register, .ch_drdy, .ch_active, .power);

// File: bench/acpm_host.sv
// partner model: phase strobes and filter results
// assumes the strobe source already applies each phase delay
module acpm_host (
    input wire logic mclk,
    output logic [3:0] sample_stb = 4'h0,
    output logic [95:0] filt_data,
    output logic [15:0] mod_quant
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] n = 3'h0;
    always @(posedge mclk) begin
        n <= n + 3'h1;
        sample_stb <= {4{n == 3'h7}};
    end
    assign filt_data = {4{24'h5A3C1E}};
    assign mod_quant = 16'h9999;
endmodule

// File: bench/testbench.sv
// self-checking bench for the channel mode controller
// assumes acpm_host supplies strobes; mode and hard reset come from here
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ST = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic clear_n = 1'b1;
    logic por_active = 1'b0;
    acpm_pkg::acpm_mode_s mode = '0;
    acpm_pkg::acpm_mode_s m;
    acpm_pkg::acpm_power_s pwr;
    logic [3:0] stb, drdy, act, seen;
    logic [95:0] fd, dat;
    logic [15:0] mq, mor;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    always #25 mclk = ~mclk;
    acpm_host host (.mclk, .sample_stb(stb), .filt_data(fd), .mod_quant(mq));
    acpm_ctrl #(.SETTLE(ST)) dut (.mclk, .rst_n, .clear_n, .por_active, .mode,
        .sample_stb(stb), .filt_data(fd), .mod_quant(mq), .ch_data(dat),
        .modulator_output_register(mor), .ch_drdy(drdy), .ch_active(act), .power(pwr));
    task automatic chk(logic [95:0] got, logic [95:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one edge to land, two more to take effect, then gather pulses
    task automatic run(acpm_pkg::acpm_mode_s v, int n);
        @(posedge mclk);
        mode <= v;
        repeat (2) @(posedge mclk);
        // pulses before settling are never compared
        #1 seen = 4'h0;
        repeat (n) begin
            @(posedge mclk);
            #1 seen |= drdy;
        end
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        @(posedge mclk);
        #1 chk({dat, mor, pwr}, {96'h0, 16'h3333, 6'h3D});
        @(posedge mclk);
        rst_n <= 1'b1;
        run('0, ST + 20);
        chk({act, seen, pwr, dat}, {4'hF, 4'hF, 6'h3C, fd});
        for (int i = 0; i < 8; i++) begin
            m = '0;
            if (i < 4) m.soft_hold[i] = 1'b1;
            else m.shutdown[i-4] = 1'b1;
            run(m, 20);
            chk(seen, 4'hF ^ (4'h1 << i[1:0]));
            chk({dat[24*i[1:0]+:24], mor[4*i[1:0]+:4]}, 28'h3);
            chk(pwr, 6'h3C);
        end
        m = '0;
        m.soft_hold = 4'hF;
        run(m, 4);
        chk({pwr, dat}, {6'h1C, 96'h0});
        run('0, 1);
        chk(act, 4'h0);
        run('0, ST + 20);
        chk({act, seen, dat}, {4'hF, 4'hF, fd});
        for (int k = 0; k < 3; k++) begin
            m = '{soft_hold: 4'h0, shutdown: 4'hF, ext_reference_select: 1'b1,
                ext_clock_select: 1'b1};
            run(m, 4);
            chk({pwr, dat}, {6'h02, 96'h0});
            chk(mode, m);
            if (k == 0) m.shutdown[0] = 1'b0;
            else if (k == 1) m.ext_clock_select = 1'b0;
            else m.ext_reference_select = 1'b0;
            run(m, 4);
            chk(pwr, k == 0 ? 6'h3C : 6'h0C);
        end
        for (int h = 0; h < 2; h++) begin
            run('0, ST + 20);
            @(posedge mclk);
            clear_n <= (h != 0);
            por_active <= (h != 0);
            run('0, 8);
            chk({dat, mor, seen, pwr.if_reset}, {96'h0, 16'h3333, 4'h0, 1'b1});
            @(posedge mclk);
            clear_n <= 1'b1;
            por_active <= 1'b0;
            run('0, ST + 20);
            chk({act, seen, pwr}, {4'hF, 4'hF, 6'h3C});
        end
        stop_test();
    end
endmodule

// File: logic/acpm_ctrl.sv
// per-channel soft hold, shutdown, hard reset and full shutdown control
// assumes the filter, modulator and phase block sit outside; the phase block
// gives one common sample strobe per channel that already carries its delay

// Overview of operation
// (R1) soft hold runs converter, forces result zero
// (R2) soft hold entry forces quantizer to 0011
// (R3) channels independent; mode bits never altered here
// (R4) no data-ready pulses while in soft hold
// (R5) results valid after filter settling on exit
// (R6) hold exit keeps phase, realigns to others
// (R7) single channel hold/shutdown keeps clock running
// (R8) all held: gate core clock, auto restore
// (R9) all held: input structure clock stays on
// (R10) hard reset from pin or power-on detect
// (R11) hard reset clears data, filters, quantizers
// (R12) interface held in reset during hard reset
// (R13) leaving shutdown: enable, first pulse after settling
// (R14) host discards results within 1 ms plus settling
// (R15) shutdown only through four mode bits
// (R16) shutdown gives zero data, no pulses
// (R17) shutdown exit keeps phase, realigns to others
// (R18) all shut down: gate input and core clocks
// (R19) full shutdown: all clocks, reference, monitors off
// (R20) full shutdown keeps programmed register contents
// (R21) serial interface stays up in full shutdown
// (R22) any bit cleared re-enables supply monitors
// (R23) bit n controls channel n
module acpm_ctrl #(
    parameter int SETTLE = acpm_pkg::SETTLE_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear_n,
    input wire logic por_active,
    input wire acpm_pkg::acpm_mode_s mode,
    input wire logic [acpm_pkg::NUM_CH-1:0] sample_stb,
    input wire logic [acpm_pkg::NUM_CH*acpm_pkg::DATA_W-1:0] filt_data,
    input wire logic [acpm_pkg::NUM_CH*acpm_pkg::QUANT_W-1:0] mod_quant,
    output logic [acpm_pkg::NUM_CH*acpm_pkg::DATA_W-1:0] ch_data,
    output logic [acpm_pkg::NUM_CH*acpm_pkg::QUANT_W-1:0] modulator_output_register,
    output logic [acpm_pkg::NUM_CH-1:0] ch_drdy,
    output logic [acpm_pkg::NUM_CH-1:0] ch_active,
    output acpm_pkg::acpm_power_s power
);
    localparam int NC = acpm_pkg::NUM_CH;
    localparam int DW = acpm_pkg::DATA_W;
    localparam int QW = acpm_pkg::QUANT_W;
    localparam logic [acpm_pkg::SETTLE_W-1:0] SETTLE_LAST =
        acpm_pkg::SETTLE_W'(SETTLE - 1);

    typedef struct packed {
        acpm_pkg::acpm_ch_s [NC-1:0] ch;
        acpm_pkg::acpm_power_s pwr;
    } acpm_state_s;

    acpm_state_s state_q;
    acpm_state_s state_d;
    logic hard_rst;
    logic all_shut;
    logic all_held;
    logic full_sd;

    // ------------------------------------------------------------
    // hard reset and chip-wide power decisions
    // ------------------------------------------------------------
    // (R10) pin or power-on detect
    assign hard_rst = !clear_n || por_active;
    // (R15) only the shutdown field steers shutdown
    assign all_shut = (mode.shutdown == acpm_pkg::ALL_CH);
    // a channel in shutdown also counts as not converting
    assign all_held = ((mode.soft_hold | mode.shutdown) == acpm_pkg::ALL_CH);
    // (R19) full shutdown condition
    assign full_sd = all_shut && mode.ext_reference_select && mode.ext_clock_select;

    always_comb begin
        state_d = state_q;
        // (R7) core clock runs while any channel converts
        // (R8) all held: core clock gated, restored on any resume
        state_d.pwr.core_clk_en = !all_held;
        // (R9) input clock stays on under hold
        // (R18) all shut down: input clock gated too
        state_d.pwr.input_clk_en = !all_shut;
        state_d.pwr.full_shutdown = full_sd;
        // (R19) reference off in full shutdown only
        state_d.pwr.ref_en = !full_sd;
        // (R22) monitors back as soon as any bit clears
        state_d.pwr.supply_mon_en = !full_sd;
        // (R12) interface held in reset; (R21) not for full shutdown
        state_d.pwr.if_reset = hard_rst;
        for (int i = 0; i < NC; i++) begin
            state_d.ch[i].drdy = 1'b0;
            // (R23) bit i steers channel i
            // (R16) shutdown wins: zero data, no pulses
            if (mode.shutdown[i]) begin
                state_d.ch[i].st = acpm_pkg::ACPM_OFF;
                state_d.ch[i].data = '0;
                state_d.ch[i].quant = acpm_pkg::QUANT_DEFAULT;
                state_d.ch[i].cnt = '0;
            // (R1) hold: result forced to zero
            end else if (mode.soft_hold[i]) begin
                state_d.ch[i].st = acpm_pkg::ACPM_HOLD;
                state_d.ch[i].data = '0;
                // (R2) quantizer pattern on hold
                state_d.ch[i].quant = acpm_pkg::QUANT_DEFAULT;
                state_d.ch[i].cnt = '0;
            end else begin
                // modulator keeps running and updating its output
                state_d.ch[i].quant = mod_quant[i*QW +: QW];
                case (state_q.ch[i].st)
                    acpm_pkg::ACPM_OFF,
                    acpm_pkg::ACPM_HOLD: begin
                        // (R13) enabled, filter settling begins
                        state_d.ch[i].st = acpm_pkg::ACPM_SETTLE;
                        state_d.ch[i].cnt = '0;
                    end
                    acpm_pkg::ACPM_SETTLE: begin
                        // (R5) valid after settling time
                        if (state_q.ch[i].cnt >= SETTLE_LAST) begin
                            state_d.ch[i].st = acpm_pkg::ACPM_RUN;
                        end else begin
                            state_d.ch[i].cnt = state_q.ch[i].cnt + 1'b1;
                        end
                    end
                    acpm_pkg::ACPM_RUN: begin
                        // (R6) (R17) common phase strobe realigns returning channel
                        if (sample_stb[i]) begin
                            state_d.ch[i].data = filt_data[i*DW +: DW];
                            state_d.ch[i].drdy = 1'b1;
                        end
                    end
                    default: begin
                        state_d.ch[i].st = acpm_pkg::ACPM_OFF;
                    end
                endcase
            end
            // (R11) hard reset clears data, filter state, quantizers
            if (hard_rst) begin
                state_d.ch[i].st = acpm_pkg::ACPM_SETTLE;
                state_d.ch[i].cnt = '0;
                state_d.ch[i].data = '0;
                state_d.ch[i].quant = acpm_pkg::QUANT_DEFAULT;
                state_d.ch[i].drdy = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // (R20) mode bits live outside; full shutdown never clears them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NC; i++) begin
                state_q.ch[i] <= '{st: acpm_pkg::ACPM_SETTLE, cnt: '0, data: '0,
                                   quant: acpm_pkg::QUANT_DEFAULT, drdy: 1'b0};
            end
            state_q.pwr <= '{core_clk_en: 1'b1, input_clk_en: 1'b1, ref_en: 1'b1,
                             supply_mon_en: 1'b1, full_shutdown: 1'b0, if_reset: 1'b1};
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // (R4) (R16) pulses only from running channels
    for (genvar g = 0; g < NC; g++) begin : g_out
        assign ch_data[g*DW +: DW] = state_q.ch[g].data;
        assign modulator_output_register[g*QW +: QW] = state_q.ch[g].quant;
        assign ch_drdy[g] = state_q.ch[g].drdy;
        assign ch_active[g] = (state_q.ch[g].st == acpm_pkg::ACPM_RUN);
    end
    assign power = state_q.pwr;
endmodule

// File: logic/acpm_pkg.sv
// package for the per-channel converter mode controller
// assumes one master clock domain; all mode bits arrive as plain ports
package acpm_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 24;
    localparam int QUANT_W = 4;
    // quantizer pattern forced on hold and hard reset
    localparam logic [3:0] QUANT_DEFAULT = 4'h3;
    // reset values of the mode bits, then the all-channels mask
    localparam logic [3:0] SOFT_HOLD_RST = 4'h0;
    localparam logic [3:0] SHUTDOWN_RST = 4'h0;
    localparam logic [3:0] ALL_CH = 4'hF;
    // default decimation settling, in master clock cycles
    localparam int SETTLE_CYC = 16;
    localparam int SETTLE_W = 16;

    typedef struct packed {
        logic [NUM_CH-1:0] soft_hold;
        logic [NUM_CH-1:0] shutdown;
        logic ext_reference_select;
        logic ext_clock_select;
    } acpm_mode_s;

    typedef struct packed {
        logic core_clk_en;
        logic input_clk_en;
        logic ref_en;
        logic supply_mon_en;
        logic full_shutdown;
        logic if_reset;
    } acpm_power_s;

    typedef enum logic [1:0] {
        ACPM_OFF = 2'b00,
        ACPM_HOLD = 2'b01,
        ACPM_SETTLE = 2'b10,
        ACPM_RUN = 2'b11
    } acpm_ch_e;

    typedef struct packed {
        acpm_ch_e st;
        logic [SETTLE_W-1:0] cnt;
        logic [DATA_W-1:0] data;
        logic [QUANT_W-1:0] quant;
        logic drdy;
    } acpm_ch_s;
endpackage
